// [rtl/rddw_top.sv]
// reset delay timer, supply droop reset and watchdog with apb registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) hold core in reset while delay runs
// (R2) delay timer counts on own rc tick
// (R3) power-up delay starts once clear pin high
// (R4) watchdog, clear, wake, droop restart delay
// (R5) rc mode later delays short, else long
// (R6) enabled droop past minimum duration resets
// (R7) stay reset until supply good, then delay
// (R8) droop during delay reinitialises delay
// (R9) droop enable bit0, off after power-on
// (R10) watchdog on own tick, runs in sleep
// (R11) watchdog timeout resets, clears timeout flag
// (R12) fuse forces watchdog on, else soft bit
// (R13) 18 ms base, prescaler up to 1:128
// (R14) clear-watchdog clears counter and prescaler
// (R15) sleep clears counter and prescaler
// (R16) run and sleep regulator level selects
// (R17) status exposes timeout, powerdown, wake flags
// (R18) sleep sets flags and stops oscillator
// (R19) pin change in sleep clears flag, resets
// (R20) any wake-up clears watchdog counter
// (R21) rate bits pick power-of-two division
module rddw_top #(
  parameter int DELAY_LONG = rddw_pkg::DELAY_LONG_CYC,
  parameter int DELAY_SHORT = rddw_pkg::DELAY_SHORT_CYC,
  parameter int WATCHDOG_PERIOD = rddw_pkg::WATCHDOG_PERIOD_CYC,
  parameter int DROOP_MIN = rddw_pkg::DROOP_MIN_CYC,
  parameter int RC_DIV = rddw_pkg::RC_TICK_DIV,
  parameter int WAKE_PINS = 5
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_clear_n,
  input wire logic supply_below_threshold,
  input wire logic external_rc_osc_mode,
  input wire logic watchdog_fuse_enable,
  input wire logic [WAKE_PINS-1:0] wake_pins,
  output logic core_reset,
  output logic main_osc_enable,
  output logic run_regulator_level,
  output logic sleep_regulator_level,
  output logic droop_level_select,
  output logic [7:0] status_bits
);
  localparam int CW = 32;

  rddw_pkg::rddw_state_e state_q;
  logic [7:0] timer_option_q;
  logic [7:0] extra_option_q;
  logic timeout_flag_n_q;
  logic powerdown_flag_n_q;
  logic pin_change_wake_flag_q;
  logic asleep_q;
  logic first_done_q;
  logic [CW-1:0] delay_cnt_q;
  logic [CW-1:0] droop_cnt_q;
  logic [CW-1:0] rc_div_q;
  logic rc_tick;
  logic [CW-1:0] wd_cnt_q;
  logic [6:0] wd_pre_q;
  logic [WAKE_PINS-1:0] wake_ref_q;
  logic watchdog_on;
  logic wd_tick;
  logic wd_timeout;
  logic droop_reset;
  logic pin_wake;
  logic master_clear_n_event;
  logic master_clear_n_n_prev_q;
  logic reset_event;
  logic apb_write;
  logic apb_read;
  rddw_pkg::rddw_cmd_s cmd;

  function automatic logic [6:0] pre_mask(input logic [2:0] rate);
    pre_mask = 7'(({7'h00, 1'b1} << rate) - 8'h01);
  endfunction : pre_mask

  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && !penable && !pwrite;
  assign cmd.clear_watchdog_instr = apb_write && (paddr == rddw_pkg::OFF_CONTROL)
                                    && pwdata[rddw_pkg::CMD_CLEAR_WATCHDOG_BIT];
  assign cmd.sleep_instr = apb_write && (paddr == rddw_pkg::OFF_CONTROL)
                           && pwdata[rddw_pkg::CMD_SLEEP_BIT];

  // rc tick stands in for the on-chip rc oscillators of delay and watchdog
  always_ff @(posedge clk_sys) begin
    if (sys_rst || rc_tick) begin
      rc_div_q <= '0;
    end else begin
      rc_div_q <= rc_div_q + 32'h1;
    end
  end
  assign rc_tick = (rc_div_q == CW'(RC_DIV - 1));

  assign watchdog_on = watchdog_fuse_enable
                       || extra_option_q[rddw_pkg::WATCHDOG_SOFT_ENABLE_BIT]; // [R12]

  // droop must persist past the minimum duration before it counts
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply_below_threshold
        || !extra_option_q[rddw_pkg::DROOP_DETECT_ENABLE_BIT]) begin
      droop_cnt_q <= '0;
    end else if (droop_cnt_q < CW'(DROOP_MIN)) begin
      droop_cnt_q <= droop_cnt_q + 32'h1;
    end
  end
  assign droop_reset = (droop_cnt_q >= CW'(DROOP_MIN)); // [R6]

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      master_clear_n_n_prev_q <= 1'b0;
    end else begin
      master_clear_n_n_prev_q <= master_clear_n;
    end
  end
  assign master_clear_n_event = master_clear_n_n_prev_q && !master_clear_n;
  assign pin_wake = asleep_q && extra_option_q[rddw_pkg::PIN_CHANGE_WAKE_ENABLE_BIT]
                    && (wake_pins != wake_ref_q);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !asleep_q) begin
      wake_ref_q <= wake_pins;
    end
  end

  // watchdog with optional prescaler on its own tick
  assign wd_tick = rc_tick && watchdog_on && (
                   !timer_option_q[rddw_pkg::PRESCALER_ASSIGN_BIT]
                   || ((wd_pre_q & pre_mask(timer_option_q[2:0]))
                       == pre_mask(timer_option_q[2:0]))); // [R21] [R13]
  assign wd_timeout = wd_tick && (wd_cnt_q >= CW'(WATCHDOG_PERIOD / RC_DIV - 1));
  assign reset_event = wd_timeout || master_clear_n_event || pin_wake || droop_reset;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || cmd.clear_watchdog_instr || cmd.sleep_instr
        || (asleep_q && reset_event) || wd_timeout) begin
      wd_cnt_q <= '0; // [R14] [R15] [R20]
      wd_pre_q <= '0;
    end else if (rc_tick && watchdog_on) begin // [R10]
      wd_pre_q <= wd_pre_q + 7'h01;
      if (wd_tick) begin
        wd_cnt_q <= wd_cnt_q + 32'h1;
      end
    end
  end

  // reset sequencing
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= rddw_pkg::RDDW_POR_WAIT;
      delay_cnt_q <= '0;
      first_done_q <= 1'b0;
    end else begin
      case (state_q)
        rddw_pkg::RDDW_POR_WAIT: begin
          delay_cnt_q <= CW'(DELAY_LONG / RC_DIV);
          if (master_clear_n) begin
            state_q <= rddw_pkg::RDDW_DELAY; // [R3]
          end
        end
        rddw_pkg::RDDW_SUPPLY_WAIT: begin
          delay_cnt_q <= (external_rc_osc_mode && first_done_q)
                         ? CW'(DELAY_SHORT / RC_DIV) : CW'(DELAY_LONG / RC_DIV); // [R5]
          if (!supply_below_threshold && master_clear_n) begin
            state_q <= rddw_pkg::RDDW_DELAY; // [R7]
          end
        end
        rddw_pkg::RDDW_DELAY: begin
          if (droop_reset || supply_below_threshold && first_done_q || !master_clear_n) begin
            state_q <= rddw_pkg::RDDW_SUPPLY_WAIT; // [R8]
          end else if (rc_tick) begin // [R2]
            if (delay_cnt_q <= 32'h1) begin
              state_q <= rddw_pkg::RDDW_RUN;
              first_done_q <= 1'b1;
            end else begin
              delay_cnt_q <= delay_cnt_q - 32'h1;
            end
          end
        end
        rddw_pkg::RDDW_RUN: begin
          if (reset_event) begin
            state_q <= rddw_pkg::RDDW_SUPPLY_WAIT; // [R4]
          end
        end
        default: begin
          state_q <= rddw_pkg::RDDW_POR_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= (state_q != rddw_pkg::RDDW_RUN) || reset_event; // [R1]
    end
  end

  // sleep state and oscillator driver
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reset_event) begin
      asleep_q <= 1'b0;
    end else if (cmd.sleep_instr && state_q == rddw_pkg::RDDW_RUN) begin
      asleep_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      main_osc_enable <= 1'b1;
    end else begin
      main_osc_enable <= !(asleep_q || cmd.sleep_instr) || reset_event; // [R18]
    end
  end

  // status flags; hardware events outrank software commands
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timeout_flag_n_q <= 1'b1;
      powerdown_flag_n_q <= 1'b1;
      pin_change_wake_flag_q <= 1'b1;
    end else begin
      if (wd_timeout) begin
        timeout_flag_n_q <= 1'b0; // [R11]
      end else if (cmd.sleep_instr || cmd.clear_watchdog_instr) begin
        timeout_flag_n_q <= 1'b1; // [R18]
      end
      if (cmd.sleep_instr) begin
        powerdown_flag_n_q <= 1'b0; // [R18]
      end else if (cmd.clear_watchdog_instr) begin
        powerdown_flag_n_q <= 1'b1;
      end
      if (pin_wake) begin
        pin_change_wake_flag_q <= 1'b0; // [R19]
      end else if (cmd.sleep_instr) begin
        pin_change_wake_flag_q <= 1'b1; // [R18]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_bits <= 8'h98;
    end else begin
      status_bits <= {pin_change_wake_flag_q, 2'b00, timeout_flag_n_q,
                      powerdown_flag_n_q, 1'b0, asleep_q,
                      state_q != rddw_pkg::RDDW_RUN}; // [R17]
    end
  end

  // option registers; droop detector off from power-on until bit0 is written
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer_option_q <= rddw_pkg::TIMER_OPTION_RESET;
      extra_option_q <= rddw_pkg::EXTRA_OPTION_RESET; // [R9]
    end else if (apb_write && paddr == rddw_pkg::OFF_TIMER_OPTION) begin
      timer_option_q <= pwdata[7:0] & rddw_pkg::TIMER_OPTION_MASK; // [R13]
    end else if (apb_write && paddr == rddw_pkg::OFF_EXTRA_OPTION) begin
      extra_option_q <= pwdata[7:0] & rddw_pkg::EXTRA_OPTION_MASK; // [R9]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_regulator_level <= rddw_pkg::EXTRA_OPTION_RESET[rddw_pkg::RUN_REGULATOR_LEVEL_BIT];
      sleep_regulator_level <= rddw_pkg::EXTRA_OPTION_RESET[rddw_pkg::SLEEP_REGULATOR_LEVEL_BIT];
      droop_level_select <= rddw_pkg::EXTRA_OPTION_RESET[rddw_pkg::DROOP_LEVEL_SELECT_BIT];
    end else begin
      run_regulator_level <= extra_option_q[rddw_pkg::RUN_REGULATOR_LEVEL_BIT]; // [R16]
      sleep_regulator_level <= extra_option_q[rddw_pkg::SLEEP_REGULATOR_LEVEL_BIT]; // [R16]
      droop_level_select <= extra_option_q[rddw_pkg::DROOP_LEVEL_SELECT_BIT];
    end
  end

  // apb: read data captured in setup, answer in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        if (paddr == rddw_pkg::OFF_TIMER_OPTION) begin
          prdata <= {24'h000000, timer_option_q};
        end else if (paddr == rddw_pkg::OFF_EXTRA_OPTION) begin
          prdata <= {24'h000000, extra_option_q};
        end else if (paddr == rddw_pkg::OFF_STATUS) begin
          prdata <= {24'h000000, pin_change_wake_flag_q, 2'b00, timeout_flag_n_q,
                     powerdown_flag_n_q, 1'b0, asleep_q, state_q != rddw_pkg::RDDW_RUN};
        end else if (paddr == rddw_pkg::OFF_CONTROL) begin
          prdata <= '0;
        end else begin
          prdata <= '0;
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule : rddw_top
`default_nettype wire

// [pkg/rddw_pkg.sv]
// constants, register layout and types for the reset delay and watchdog block
package rddw_pkg;
  // register byte offsets (chosen; none printed)
  localparam logic [7:0] OFF_TIMER_OPTION = 8'h00;
  localparam logic [7:0] OFF_EXTRA_OPTION = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  // timer option fields
  localparam int PRESCALER_RATE_LSB = 0;
  localparam int PRESCALER_ASSIGN_BIT = 3;
  localparam logic [7:0] TIMER_OPTION_RESET = 8'h3f;
  localparam logic [7:0] TIMER_OPTION_MASK = 8'h3f;
  // extra option fields
  localparam int DROOP_DETECT_ENABLE_BIT = 0;
  localparam int DROOP_LEVEL_SELECT_BIT = 1;
  localparam int SLEEP_REGULATOR_LEVEL_BIT = 2;
  localparam int RUN_REGULATOR_LEVEL_BIT = 3;
  localparam int WATCHDOG_SOFT_ENABLE_BIT = 4;
  localparam int PIN_CHANGE_WAKE_ENABLE_BIT = 5;
  // power-on value with droop detector forced off
  localparam logic [7:0] EXTRA_OPTION_RESET = 8'h3e;
  localparam logic [7:0] EXTRA_OPTION_MASK = 8'h3f;
  // status fields
  localparam int POWERDOWN_FLAG_BIT = 3;
  localparam int TIMEOUT_FLAG_BIT = 4;
  localparam int PIN_CHANGE_WAKE_FLAG_BIT = 7;
  localparam int IN_RESET_BIT = 0;
  localparam int ASLEEP_BIT = 1;
  // control register write bits (self clearing commands)
  localparam int CMD_CLEAR_WATCHDOG_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int DELAY_LONG_MS = 18;
  localparam int DELAY_SHORT_MS = 1;
  localparam int WATCHDOG_PERIOD_MS = 18;
  localparam int DELAY_LONG_CYC = (CLK_HZ / 1000) * DELAY_LONG_MS;
  localparam int DELAY_SHORT_CYC = (CLK_HZ / 1000) * DELAY_SHORT_MS;
  localparam int WATCHDOG_PERIOD_CYC = (CLK_HZ / 1000) * WATCHDOG_PERIOD_MS;
  localparam int DROOP_MIN_DURATION_NS = 1000;
  localparam int DROOP_MIN_CYC = (DROOP_MIN_DURATION_NS + 7) / 8;
  localparam int RC_TICK_DIV = 16;

  typedef enum logic [1:0] {
    RDDW_POR_WAIT,
    RDDW_SUPPLY_WAIT,
    RDDW_DELAY,
    RDDW_RUN
  } rddw_state_e;

  typedef struct packed {
    logic clear_watchdog_instr;
    logic sleep_instr;
  } rddw_cmd_s;
endpackage : rddw_pkg

// [testbench/rddw_asserts.sv]
// port assertions for the reset delay, droop and watchdog block
`timescale 1ns/1ps
`default_nettype none
module rddw_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic master_clear_n,
  input wire logic supply_below_threshold,
  input wire logic core_reset,
  input wire logic [7:0] status_bits
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  unmapped_error_a: assert property (psel && !penable && !pwrite && paddr > 8'h0c
    |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  mapped_no_error_a: assert property (psel && !penable && paddr <= 8'h0c
    && paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped access refused");
  clear_holds_reset_a: assert property (!master_clear_n |-> ##[1:2] core_reset)
    else $error("clear pin low without core reset");
  clear_rise_hold_a: assert property ($rose(master_clear_n) |=> core_reset [*8])
    else $error("core released right after clear pin rose");
  droop_hold_a: assert property (core_reset && supply_below_threshold |=> core_reset)
    else $error("core released while supply low");
  release_cause_a: assert property ($fell(core_reset) |-> master_clear_n
    && !supply_below_threshold) else $error("core released with a cause active");
  timeout_resets_a: assert property ($fell(status_bits[4]) |-> ##[0:2] core_reset)
    else $error("timeout flag cleared without reset");
  wake_resets_a: assert property ($fell(status_bits[7]) |-> ##[0:2] core_reset)
    else $error("wake flag cleared without reset");
endmodule : rddw_asserts
bind rddw_top rddw_asserts chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .master_clear_n(master_clear_n),
  .supply_below_threshold(supply_below_threshold), .core_reset(core_reset),
  .status_bits(status_bits)
);
`default_nettype wire

// [testbench/rddw_core_model.sv]
// model of the core and of the external clear pin
`timescale 1ns/1ps
`default_nettype none
module rddw_core_model (
  input wire logic clk_sys,
  input wire logic hold_low,
  input wire logic core_reset,
  output logic master_clear_n,
  output int reset_cycles
);
  // pin follows the board request with no filtering, the harshest case
  assign master_clear_n = !hold_low;
  // the core sits idle for as long as it is held
  always_ff @(posedge clk_sys) begin
    reset_cycles <= core_reset ? reset_cycles + 1 : 0;
  end
endmodule : rddw_core_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the reset delay, droop and watchdog block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DL = 320;
  localparam int DS = 64;
  localparam int WP = 256;
  localparam int DM = 16;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic hold = 1, sup = 0, rc = 0, fuse = 0;
  logic [7:0] paddr = 0;
  logic [4:0] wk = 0;
  logic [31:0] pwdata = 0, s = 32'h7a52, x;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, master_clear_n_n, core_reset, osc_en, rl, sl, dl;
  wire logic [7:0] st;
  int fail_count = 0, check_count = 0, cyc = 0, n, held;
  logic [32:0] rq[$];
  always #4 clk_sys = ~clk_sys;
  rddw_top #(.DELAY_LONG(DL), .DELAY_SHORT(DS), .WATCHDOG_PERIOD(WP), .DROOP_MIN(DM),
    .RC_DIV(4), .WAKE_PINS(5)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_clear_n(master_clear_n_n),
    .supply_below_threshold(sup), .external_rc_osc_mode(rc),
    .watchdog_fuse_enable(fuse), .wake_pins(wk), .core_reset(core_reset),
    .main_osc_enable(osc_en), .run_regulator_level(rl), .sleep_regulator_level(sl),
    .droop_level_select(dl), .status_bits(st));
  rddw_core_model core_u (.clk_sys(clk_sys), .hold_low(hold), .core_reset(core_reset),
    .master_clear_n(master_clear_n_n), .reset_cycles(held));
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  task automatic cmp(input string t, input logic [32:0] e, input logic [32:0] v);
    check_count++;
    if (v !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", t, e, v);
    end
  endtask : cmp
  task automatic chk(input string t, input int lo, input int hi);
    check_count++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", t, lo, hi, n);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // counts cycles until core reset reaches the level; the cycle ceiling ends a hang
  task automatic wl(input logic v);
    n = 0;
    while (core_reset !== v) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wl
  task automatic done(input string t);
    $display("test %s done", t);
  endtask : done
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready === 1'b1) cmp("prdata", rq.pop_front(),
      {pslverr, prdata});
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(rddw_pkg::OFF_STATUS, 33'h99);
    rd(rddw_pkg::OFF_TIMER_OPTION, 33'h3f);
    rd(rddw_pkg::OFF_EXTRA_OPTION, 33'h3e);
    rd(8'h10, 33'h100000000);
    @(posedge clk_sys);
    hold <= 1'b0;
    wl(1'b0);
    chk("power-up delay", DL - 8, DL + 16);
    done("power-up");
    x = rnd();
    apb(1'b1, rddw_pkg::OFF_EXTRA_OPTION, x & 32'hffffffce);
    rd(rddw_pkg::OFF_EXTRA_OPTION, 33'(x[3:1]) << 1);
    cmp("levels", 33'(x[3:1]), 33'({rl, sl, dl}));
    apb(1'b1, rddw_pkg::OFF_TIMER_OPTION, 32'h09);
    apb(1'b1, rddw_pkg::OFF_EXTRA_OPTION, 32'h10);
    wl(1'b1);
    chk("watchdog 1:2", 2 * WP - 16, 2 * WP + 32);
    rd(rddw_pkg::OFF_STATUS, 33'h89);
    wl(1'b0);
    chk("crystal delay", DL - 8, DL + 16);
    // clears spaced well inside the prescaled period
    repeat (6) begin
      apb(1'b1, rddw_pkg::OFF_CONTROL, 32'h1);
      repeat (150) @(posedge clk_sys);
    end
    cmp("no timeout", 33'h0, 33'(core_reset));
    rd(rddw_pkg::OFF_STATUS, 33'h98);
    done("watchdog");
    rc <= 1'b1;
    apb(1'b1, rddw_pkg::OFF_EXTRA_OPTION, 32'h30);
    apb(1'b1, rddw_pkg::OFF_CONTROL, 32'h2);
    wl(1'b1);
    chk("sleep timeout", 2 * WP - 16, 2 * WP + 32);
    rd(rddw_pkg::OFF_STATUS, 33'h81);
    wl(1'b0);
    chk("rc delay", DS - 8, DS + 16);
    cmp("osc on", 33'h1, 33'(osc_en));
    apb(1'b1, rddw_pkg::OFF_EXTRA_OPTION, 32'h20);
    apb(1'b1, rddw_pkg::OFF_CONTROL, 32'h2);
    rd(rddw_pkg::OFF_STATUS, 33'h92);
    cmp("osc off", 33'h0, 33'(osc_en));
    wk <= wk ^ (5'h01 | 5'(rnd()));
    wl(1'b1);
    chk("pin wake", 0, 8);
    rd(rddw_pkg::OFF_STATUS, 33'h11);
    wl(1'b0);
    chk("wake delay", DS - 8, DS + 16);
    done("sleep");
    rc <= 1'b0;
    apb(1'b1, rddw_pkg::OFF_EXTRA_OPTION, 32'h01);
    sup <= 1'b1;
    repeat (DM - 6) @(posedge clk_sys);
    sup <= 1'b0;
    repeat (20) @(posedge clk_sys);
    cmp("short droop", 33'h0, 33'(core_reset));
    sup <= 1'b1;
    wl(1'b1);
    chk("droop", DM - 2, DM + 8);
    repeat (50) @(posedge clk_sys);
    sup <= 1'b0;
    repeat (100) @(posedge clk_sys);
    sup <= 1'b1;
    repeat (DM + 20) @(posedge clk_sys);
    sup <= 1'b0;
    wl(1'b0);
    chk("droop restart", DL - 8, DL + 16);
    done("droop");
    hold <= 1'b1;
    repeat (5) @(posedge clk_sys);
    hold <= 1'b0;
    wl(1'b0);
    chk("clear pin delay", DL - 8, DL + 16);
    apb(1'b1, rddw_pkg::OFF_TIMER_OPTION, 32'h0);
    apb(1'b1, rddw_pkg::OFF_EXTRA_OPTION, 32'h0);
    fuse <= 1'b1;
    wl(1'b1);
    chk("fused watchdog", WP - 16, WP + 32);
    fuse <= 1'b0;
    wl(1'b0);
    done("fuse");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
